// *** verilog/cfbm_pkg.sv ***
// Constants and types shared by the flag, bit and memory execution unit.
// Assumes one core clock and a synchronous active-high reset.
// How it works
// RULE1: Bit-to-flag store copies a source register bit into T, one cycle.
// RULE2: Flag-to-bit load writes T into a destination bit, flags kept, one cycle.
// RULE3: Overflow set and clear force V only, one cycle.
// RULE4: Sign set and clear force S only, one cycle.
// RULE5: Half-carry set and clear force H only, one cycle.
// RULE6: Post-increment load reads at pointer, then pointer plus one, two cycles.
// RULE7: Pre-decrement load lowers pointer first, reads new address, two cycles.
// RULE8: Displaced load reads Y or Z plus displacement, pointer kept, two cycles.
// RULE9: Post-increment store writes at pointer, then pointer plus one, two cycles.
// RULE10: Pre-decrement store lowers pointer first, then writes, two cycles.
// RULE11: Displaced store writes at Y or Z plus displacement, pointer kept.
// RULE12: Direct load reads the immediate address into a register, two cycles.
// RULE13: Direct store writes a register at the immediate address, two cycles.
// RULE14: Push places a register on the stack, flags kept, two cycles.
// RULE15: Pop moves the stack top into a register, flags kept, two cycles.
// RULE16: Watchdog restart pulses the watchdog restart, one cycle.
// RULE17: Break raises a debug halt request and changes no flag.
// RULE18: Global interrupt on and off set or clear I only, one cycle.
// RULE19: Program memory read uses Z, three cycles, optional post-increment.
// RULE20: Nibble exchange swaps register halves in one cycle, flags kept.
package cfbm_pkg;
   localparam int unsigned CFBM_FLAG_C = 0;
   localparam int unsigned CFBM_FLAG_H = 5;
   localparam int unsigned CFBM_FLAG_S = 4;
   localparam int unsigned CFBM_FLAG_V = 3;
   localparam int unsigned CFBM_FLAG_T = 6;
   localparam int unsigned CFBM_FLAG_I = 7;
   localparam logic [7:0] CFBM_STATUS_RST = 8'h00;
   localparam logic [15:0] CFBM_SP_RST = 16'h00ff;
   localparam logic [1:0] CFBM_CYC_MEM = 2'h2;
   localparam logic [1:0] CFBM_CYC_PMEM = 2'h3;

   typedef enum logic [4:0] {
      CFBM_OP_NONE = 5'h00, CFBM_OP_BIT_TO_FLAG = 5'h01, CFBM_OP_FLAG_TO_BIT = 5'h02,
      CFBM_OP_FLAG_SET = 5'h03, CFBM_OP_FLAG_CLR = 5'h04,
      CFBM_OP_LOAD = 5'h05, CFBM_OP_STORE = 5'h06, CFBM_OP_LOAD_DIR = 5'h07,
      CFBM_OP_STORE_DIR = 5'h08, CFBM_OP_PUSH = 5'h09, CFBM_OP_POP = 5'h0a,
      CFBM_OP_WDOG = 5'h0b, CFBM_OP_BRK = 5'h0c, CFBM_OP_PM_READ = 5'h0d,
      CFBM_OP_SWAP = 5'h0e
   } cfbm_op_t;

   typedef enum logic [1:0] {
      CFBM_AM_PLAIN = 2'h0, CFBM_AM_POSTINC = 2'h1,
      CFBM_AM_PREDEC = 2'h2, CFBM_AM_DISP = 2'h3
   } cfbm_amode_t;

   typedef enum logic [3:0] {
      CFBM_SEQ_IDLE = 4'b0001, CFBM_SEQ_MEM = 4'b0010,
      CFBM_SEQ_PM1 = 4'b0100, CFBM_SEQ_PM2 = 4'b1000
   } cfbm_state_t;
endpackage

// *** verilog/cfbm_mem_if.sv ***
// Data memory request bundle between the sequencer and the address unit.
// Assumes both ends run on the core clock.
`timescale 1ns/10ps
interface cfbm_mem_if;
   logic [15:0] ptr;
   logic [5:0] disp;
   logic use_disp;
   logic predec;
   logic [15:0] addr;
   logic [15:0] ptr_next;
   modport seq (output ptr, output disp, output use_disp, output predec,
                input addr, input ptr_next);
   modport agu (input ptr, input disp, input use_disp, input predec,
                output addr, output ptr_next);
endinterface // cfbm_mem_if

// *** verilog/cfbm_agu.sv ***
// Address unit for pointer-based data memory access.
// Assumes pointer and displacement stay stable while an access is issued.
`timescale 1ns/10ps
module cfbm_agu
   import cfbm_pkg::*;
(
   cfbm_mem_if.agu m
);
   logic [15:0] dec;
   assign dec = m.ptr - 16'h0001;
   // Pre-decrement addresses the lowered pointer, displacement the pointer plus disp, otherwise the pointer.
   assign m.addr = m.predec ? dec :
                   (m.use_disp ? m.ptr + {10'h000, m.disp} : m.ptr); // see RULE7 RULE8 RULE11
   assign m.ptr_next = m.predec ? dec : m.ptr + 16'h0001; // see RULE6 RULE9
endmodule // cfbm_agu

// *** verilog/cfbm_top.sv ***
// Execution unit for flag, bit transfer, data memory, stack and control ops.
// Assumes the fetch unit holds op inputs valid for one cycle when idle.
`timescale 1ns/10ps
module cfbm_top
   import cfbm_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Decoded instruction.
   input wire logic op_valid_i,
   input wire cfbm_op_t op_i,
   input wire cfbm_amode_t amode_i,
   input wire logic [1:0] ptr_sel_i,
   input wire logic [5:0] disp_i,
   input wire logic [2:0] bit_i,
   input wire logic [15:0] imm_addr_i,
   // Register file.
   input wire logic [7:0] rs_data_i,
   input wire logic [7:0] rd_data_i,
   input wire logic [15:0] ptr_x_i,
   input wire logic [15:0] ptr_y_i,
   input wire logic [15:0] ptr_z_i,
   output logic rd_we_o,
   output logic [7:0] rd_wdata_o,
   output logic ptr_we_o,
   output logic [15:0] ptr_wdata_o,
   // Data and program memory.
   output logic dm_re_o,
   output logic dm_we_o,
   output logic [15:0] dm_addr_o,
   output logic [7:0] dm_wdata_o,
   input wire logic [7:0] dm_rdata_i,
   output logic pm_re_o,
   output logic [15:0] pm_addr_o,
   input wire logic [7:0] pm_rdata_i,
   // Status, stack and control.
   output logic [7:0] status_register_o,
   output logic [15:0] sp_o,
   output logic busy_o,
   output logic wdog_restart_o,
   output logic dbg_halt_o
);
   cfbm_mem_if mi ();
   cfbm_agu u_agu (.m(mi));

   cfbm_state_t state_q;
   logic [7:0] status_q;
   logic [15:0] sp_q;
   logic [1:0] cnt_q;
   logic is_load_q;
   logic upd_ptr_q;
   logic [15:0] ptr_nx_q;
   logic pm_inc_q;
   logic [15:0] ptr_sel;
   logic go;
   logic mem_op;

   assign go = op_valid_i && (state_q == CFBM_SEQ_IDLE);
   assign mem_op = (op_i == CFBM_OP_LOAD) || (op_i == CFBM_OP_STORE) ||
                   (op_i == CFBM_OP_LOAD_DIR) || (op_i == CFBM_OP_STORE_DIR) ||
                   (op_i == CFBM_OP_PUSH) || (op_i == CFBM_OP_POP);

   always_comb
   begin
      unique case (ptr_sel_i)
         2'h1: ptr_sel = ptr_y_i;
         2'h2: ptr_sel = ptr_z_i;
         default: ptr_sel = ptr_x_i;
      endcase
   end

   // ----------------------------------------
   // Address unit drive
   // ----------------------------------------
   assign mi.ptr = (op_i == CFBM_OP_PM_READ) ? ptr_z_i : ptr_sel;
   assign mi.disp = disp_i;
   assign mi.use_disp = (amode_i == CFBM_AM_DISP) && (ptr_sel_i != 2'h0);
   assign mi.predec = (amode_i == CFBM_AM_PREDEC) && (op_i != CFBM_OP_PM_READ);

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         state_q <= CFBM_SEQ_IDLE;
         cnt_q <= 2'h0;
      end
      else
      begin
         unique case (state_q)
            CFBM_SEQ_IDLE:
            begin
               if (go && mem_op)
               begin
                  state_q <= CFBM_SEQ_MEM;
                  cnt_q <= CFBM_CYC_MEM - 2'h1; // see RULE6 RULE12 RULE14
               end
               else if (go && op_i == CFBM_OP_PM_READ)
               begin
                  state_q <= CFBM_SEQ_PM1;
                  cnt_q <= CFBM_CYC_PMEM - 2'h1; // see RULE19
               end
            end
            CFBM_SEQ_PM1:
            begin
               state_q <= CFBM_SEQ_PM2;
               cnt_q <= cnt_q - 2'h1;
            end
            CFBM_SEQ_MEM, CFBM_SEQ_PM2:
            begin
               cnt_q <= cnt_q - 2'h1;
               if (cnt_q == 2'h1)
                  state_q <= CFBM_SEQ_IDLE;
            end
            default:
               state_q <= CFBM_SEQ_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Memory access issue
   // ----------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         dm_re_o <= 1'b0;
         dm_we_o <= 1'b0;
         dm_addr_o <= 16'h0000;
         dm_wdata_o <= 8'h00;
         pm_re_o <= 1'b0;
         pm_addr_o <= 16'h0000;
         is_load_q <= 1'b0;
         upd_ptr_q <= 1'b0;
         ptr_nx_q <= 16'h0000;
         pm_inc_q <= 1'b0;
      end
      else
      begin
         dm_re_o <= 1'b0;
         dm_we_o <= 1'b0;
         pm_re_o <= 1'b0;
         if (go && mem_op)
         begin
            dm_wdata_o <= rs_data_i;
            ptr_nx_q <= mi.ptr_next;
            is_load_q <= (op_i == CFBM_OP_LOAD) || (op_i == CFBM_OP_LOAD_DIR) ||
                         (op_i == CFBM_OP_POP);
            dm_re_o <= (op_i == CFBM_OP_LOAD) || (op_i == CFBM_OP_LOAD_DIR) ||
                       (op_i == CFBM_OP_POP);
            dm_we_o <= (op_i == CFBM_OP_STORE) || (op_i == CFBM_OP_STORE_DIR) ||
                       (op_i == CFBM_OP_PUSH);
            upd_ptr_q <= ((op_i == CFBM_OP_LOAD) || (op_i == CFBM_OP_STORE)) &&
                         ((amode_i == CFBM_AM_POSTINC) ||
                          (amode_i == CFBM_AM_PREDEC)); // see RULE6 RULE7 RULE9 RULE10
            unique case (op_i)
               CFBM_OP_LOAD_DIR, CFBM_OP_STORE_DIR: dm_addr_o <= imm_addr_i; // see RULE12 RULE13
               CFBM_OP_PUSH: dm_addr_o <= sp_q; // see RULE14
               CFBM_OP_POP: dm_addr_o <= sp_q + 16'h0001; // see RULE15
               default: dm_addr_o <= mi.addr; // see RULE8 RULE11
            endcase
         end
         else if (go && op_i == CFBM_OP_PM_READ)
         begin
            pm_re_o <= 1'b1;
            pm_addr_o <= ptr_z_i; // see RULE19
            ptr_nx_q <= mi.ptr_next;
            pm_inc_q <= (amode_i == CFBM_AM_POSTINC);
            is_load_q <= 1'b0;
            upd_ptr_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Register file write back
   // ----------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         rd_we_o <= 1'b0;
         rd_wdata_o <= 8'h00;
         ptr_we_o <= 1'b0;
         ptr_wdata_o <= 16'h0000;
      end
      else
      begin
         rd_we_o <= 1'b0;
         ptr_we_o <= 1'b0;
         if (go && op_i == CFBM_OP_FLAG_TO_BIT)
         begin
            rd_we_o <= 1'b1;
            rd_wdata_o <= rd_data_i;
            rd_wdata_o[bit_i] <= status_q[CFBM_FLAG_T]; // see RULE2
         end
         else if (go && op_i == CFBM_OP_SWAP)
         begin
            rd_we_o <= 1'b1;
            rd_wdata_o <= {rd_data_i[3:0], rd_data_i[7:4]}; // see RULE20
         end
         else if (state_q == CFBM_SEQ_MEM)
         begin
            rd_we_o <= is_load_q;
            rd_wdata_o <= dm_rdata_i; // see RULE6 RULE12 RULE15
            ptr_we_o <= upd_ptr_q;
            ptr_wdata_o <= ptr_nx_q; // see RULE6 RULE7 RULE9 RULE10
         end
         else if (state_q == CFBM_SEQ_PM2)
         begin
            rd_we_o <= 1'b1;
            rd_wdata_o <= pm_rdata_i; // see RULE19
            ptr_we_o <= pm_inc_q;
            ptr_wdata_o <= ptr_nx_q; // see RULE19
         end
      end
   end

   // ----------------------------------------
   // Status register
   // ----------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         status_q <= CFBM_STATUS_RST;
      else if (go)
      begin
         unique case (op_i)
            CFBM_OP_BIT_TO_FLAG: status_q[CFBM_FLAG_T] <= rs_data_i[bit_i]; // see RULE1
            CFBM_OP_FLAG_SET: status_q[bit_i] <= 1'b1; // see RULE3 RULE4 RULE5 RULE18
            CFBM_OP_FLAG_CLR: status_q[bit_i] <= 1'b0; // see RULE3 RULE4 RULE5 RULE18
            default: status_q <= status_q;
         endcase
      end
   end

   // ----------------------------------------
   // Stack pointer
   // ----------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         sp_q <= CFBM_SP_RST;
      else if (go && op_i == CFBM_OP_PUSH)
         sp_q <= sp_q - 16'h0001; // see RULE14
      else if (go && op_i == CFBM_OP_POP)
         sp_q <= sp_q + 16'h0001; // see RULE15
   end

   // ----------------------------------------
   // Watchdog and debug
   // ----------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         wdog_restart_o <= 1'b0;
         dbg_halt_o <= 1'b0;
      end
      else
      begin
         wdog_restart_o <= go && (op_i == CFBM_OP_WDOG); // see RULE16
         if (go && op_i == CFBM_OP_BRK)
            dbg_halt_o <= 1'b1; // see RULE17
      end
   end

   assign status_register_o = status_q;
   assign sp_o = sp_q;
   assign busy_o = (state_q != CFBM_SEQ_IDLE);
endmodule // cfbm_top

// *** tb/cfbm_props.sv ***
// Assertions on the ports of the flag, bit and memory execution unit.
// Assumes it is bound to cfbm_top and runs on the core clock.
`timescale 1ns/10ps
module cfbm_props
   import cfbm_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Instruction.
   input wire logic op_valid_i,
   input wire cfbm_op_t op_i,
   input wire logic [2:0] bit_i,
   input wire logic [7:0] rs_data_i,
   input wire logic [7:0] rd_data_i,
   // Results.
   input wire logic busy_o,
   input wire logic rd_we_o,
   input wire logic [7:0] rd_wdata_o,
   input wire logic dm_re_o,
   input wire logic dm_we_o,
   input wire logic [7:0] dm_wdata_o,
   input wire logic pm_re_o,
   input wire logic [7:0] status_register_o,
   input wire logic [15:0] sp_o,
   input wire logic wdog_restart_o,
   input wire logic dbg_halt_o
);
   // ------
   // Properties.
   // ------
   default clocking @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   logic tk;
   logic [7:0] sr;
   assign tk = op_valid_i && !busy_o;
   assign sr = status_register_o;
   property p_bit_to_flag;
      tk && op_i == CFBM_OP_BIT_TO_FLAG |=> sr[CFBM_FLAG_T] == $past(rs_data_i[bit_i])
         && (sr & 8'hbf) == ($past(sr) & 8'hbf);
   endproperty
   property p_flag_to_bit;
      tk && op_i == CFBM_OP_FLAG_TO_BIT |=> rd_we_o && $stable(sr)
         && rd_wdata_o[$past(bit_i)] == sr[CFBM_FLAG_T]
         && ((rd_wdata_o ^ $past(rd_data_i)) & ~(8'h01 << $past(bit_i))) == 8'h00;
   endproperty
   property p_fset;
      tk && op_i == CFBM_OP_FLAG_SET |=> sr == ($past(sr) | (8'h01 << $past(bit_i)));
   endproperty
   property p_fclr;
      tk && op_i == CFBM_OP_FLAG_CLR |=> sr == ($past(sr) & ~(8'h01 << $past(bit_i)));
   endproperty
   property p_load;
      tk && op_i inside {CFBM_OP_LOAD, CFBM_OP_LOAD_DIR, CFBM_OP_POP} |=> dm_re_o && busy_o
         ##1 rd_we_o && !busy_o && $stable(sr);
   endproperty
   property p_store;
      tk && op_i inside {CFBM_OP_STORE, CFBM_OP_STORE_DIR, CFBM_OP_PUSH} |=> dm_we_o
         && busy_o && dm_wdata_o == $past(rs_data_i) ##1 !busy_o && $stable(sr);
   endproperty
   property p_push;
      tk && op_i == CFBM_OP_PUSH |=> sp_o == $past(sp_o) - 16'h0001;
   endproperty
   property p_pop;
      tk && op_i == CFBM_OP_POP |=> sp_o == $past(sp_o) + 16'h0001;
   endproperty
   property p_wdog;
      tk && op_i == CFBM_OP_WDOG |=> wdog_restart_o && $stable(sr);
   endproperty
   property p_pm_read;
      tk && op_i == CFBM_OP_PM_READ |=> pm_re_o ##1 busy_o && !rd_we_o ##1 rd_we_o && !busy_o;
   endproperty
   property p_brk;
      tk && op_i == CFBM_OP_BRK |=> dbg_halt_o && $stable(sr);
   endproperty
   a_bit_to_flag: assert property (p_bit_to_flag) else $error("bit to flag");
   a_flag_to_bit: assert property (p_flag_to_bit) else $error("flag to bit");
   a_fset: assert property (p_fset) else $error("flag set");
   a_fclr: assert property (p_fclr) else $error("flag clear");
   a_load: assert property (p_load) else $error("load timing");
   a_store: assert property (p_store) else $error("store");
   a_push: assert property (p_push) else $error("push pointer");
   a_pop: assert property (p_pop) else $error("pop pointer");
   a_wdog: assert property (p_wdog) else $error("watchdog pulse");
   a_pm_read: assert property (p_pm_read) else $error("program read");
   a_brk: assert property (p_brk) else $error("halt request");
   c_pm_read: cover property (tk && op_i == CFBM_OP_PM_READ);
   c_pop: cover property (tk && op_i == CFBM_OP_POP);
   c_flag_to_bit: cover property (tk && op_i == CFBM_OP_FLAG_TO_BIT);
endmodule // cfbm_props

bind cfbm_top cfbm_props u_cfbm_props (.clk_sys_i, .rst_i, .op_valid_i, .op_i, .bit_i,
   .rs_data_i, .rd_data_i, .busy_o, .rd_we_o, .rd_wdata_o, .dm_re_o, .dm_we_o, .dm_wdata_o,
   .pm_re_o, .status_register_o, .sp_o, .wdog_restart_o, .dbg_halt_o);

// *** tb/cfbm_mem_model.sv ***
// Data and program memory model facing the execution unit.
// Assumes the core clock; read data is valid only in its sampling cycle.
`timescale 1ns/10ps
module cfbm_mem_model
(
   // Clock.
   input wire logic clk_sys_i,
   // Data memory.
   input wire logic dm_re_i,
   input wire logic dm_we_i,
   input wire logic [15:0] dm_addr_i,
   input wire logic [7:0] dm_wdata_i,
   output logic [7:0] dm_rdata_o,
   // Program memory.
   input wire logic pm_re_i,
   input wire logic [15:0] pm_addr_i,
   output logic [7:0] pm_rdata_o
);
   logic [7:0] mem_q [256];
   logic pv_q = 1'b0;
   initial for (int i = 0; i < 256; i++) mem_q[i] = 8'(i) ^ 8'ha5;
   always @(posedge clk_sys_i)
   begin
      pv_q <= pm_re_i;
      if (dm_we_i) mem_q[dm_addr_i[7:0]] <= dm_wdata_i;
   end
   // Outside the sampling cycle the lines show the inverse, never stale data.
   assign dm_rdata_o = dm_re_i ? mem_q[dm_addr_i[7:0]] : ~mem_q[dm_addr_i[7:0]];
   assign pm_rdata_o = pv_q ? pm_addr_i[7:0] ^ 8'h3c : ~(pm_addr_i[7:0] ^ 8'h3c);
endmodule // cfbm_mem_model

// *** tb/tb.sv ***
// Self-checking bench for the flag, bit and memory execution unit.
// Assumes the memory model and the bound checker; inputs move on the falling edge.
`timescale 1ns/10ps
module tb
   import cfbm_pkg::*;
;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic op_valid_i = 1'b0;
   cfbm_op_t op_i = CFBM_OP_NONE;
   cfbm_amode_t amode_i = CFBM_AM_PLAIN;
   logic [1:0] ptr_sel_i = 2'h0;
   logic [5:0] disp_i = 6'h00;
   logic [2:0] bit_i = 3'h0;
   logic [7:0] rs_data_i = 8'h00, rd_data_i = 8'h00, dm_rdata_i, pm_rdata_i;
   logic [15:0] imm_addr_i = 16'h0000, ptr_x_i = 16'h0000;
   logic [15:0] ptr_y_i = 16'h0000, ptr_z_i = 16'h0000;
   logic rd_we_o, ptr_we_o, dm_re_o, dm_we_o, pm_re_o, busy_o, wdog_restart_o, dbg_halt_o;
   logic [7:0] rd_wdata_o, dm_wdata_o, status_register_o, sr, sh [256];
   logic [15:0] ptr_wdata_o, dm_addr_o, pm_addr_o, sp_o, sp;
   logic [31:0] seed = 32'h0000119e;
   int n_errors = 0, num_checks = 0, cyc = 0;
   int fb [4] = '{CFBM_FLAG_V, CFBM_FLAG_S, CFBM_FLAG_H, CFBM_FLAG_I};
   always #12.5 clk_sys_i = ~clk_sys_i;
   cfbm_top u_cfbm_top (.clk_sys_i, .rst_i, .op_valid_i, .op_i, .amode_i, .ptr_sel_i,
      .disp_i, .bit_i, .imm_addr_i, .rs_data_i, .rd_data_i, .ptr_x_i, .ptr_y_i, .ptr_z_i,
      .rd_we_o, .rd_wdata_o, .ptr_we_o, .ptr_wdata_o, .dm_re_o, .dm_we_o, .dm_addr_o,
      .dm_wdata_o, .dm_rdata_i, .pm_re_o, .pm_addr_o, .pm_rdata_i, .status_register_o,
      .sp_o, .busy_o, .wdog_restart_o, .dbg_halt_o);
   cfbm_mem_model u_cfbm_mem_model (.clk_sys_i, .dm_re_i(dm_re_o), .dm_we_i(dm_we_o),
      .dm_addr_i(dm_addr_o), .dm_wdata_i(dm_wdata_o), .dm_rdata_o(dm_rdata_i),
      .pm_re_i(pm_re_o), .pm_addr_i(pm_addr_o), .pm_rdata_o(pm_rdata_i));
   // ------
   // Helpers.
   // ------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(logic [23:0] seen, logic [23:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d, mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge clk_sys_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_errors++;
         finish_test();
      end
   end
   task automatic issue(cfbm_op_t o, int n);
      op_i = o;
      op_valid_i = 1'b1;
      @(negedge clk_sys_i);
      if (n > 1) op_valid_i = 1'b0;
   endtask
   task automatic idle();
      op_valid_i = 1'b0;
      @(negedge clk_sys_i);
   endtask
   // Runs one data access at address a; pw holds the expected pointer write-back.
   task automatic mop(cfbm_op_t o, logic [15:0] a, logic [16:0] pw);
      logic is_rd;
      is_rd = o inside {CFBM_OP_LOAD, CFBM_OP_LOAD_DIR, CFBM_OP_POP};
      issue(o, 2);
      chk({busy_o, dm_re_o, dm_we_o, dm_addr_o}, {1'b1, is_rd, !is_rd, a});
      if (!is_rd) chk(dm_wdata_o, rs_data_i);
      if (!is_rd) sh[a[7:0]] = rs_data_i;
      @(negedge clk_sys_i);
      chk({busy_o, rd_we_o, ptr_we_o, status_register_o}, {1'b0, is_rd, pw[16], sr});
      if (is_rd) chk(rd_wdata_o, sh[a[7:0]]);
      if (pw[16]) chk(ptr_wdata_o, pw[15:0]);
   endtask
   initial
   begin
      logic [15:0] p, a;
      logic [16:0] pw;
      repeat (5) @(negedge clk_sys_i);
      rst_i = 1'b0;
      sr = CFBM_STATUS_RST;
      sp = CFBM_SP_RST;
      for (int i = 0; i < 256; i++) sh[i] = 8'(i) ^ 8'ha5;
      chk({sp_o, status_register_o}, {sp, sr});
      for (int k = 0; k < 8; k++)
      begin
         bit_i = 3'(fb[k / 2]);
         issue(k[0] ? CFBM_OP_FLAG_SET : CFBM_OP_FLAG_CLR, 1);
         sr[fb[k / 2]] = k[0];
         chk(status_register_o, sr);
      end
      for (int k = 0; k < 8; k++)
      begin
         rs_data_i = 8'(rnd());
         bit_i = 3'(k);
         issue(CFBM_OP_BIT_TO_FLAG, 1);
         sr[CFBM_FLAG_T] = rs_data_i[k];
         chk(status_register_o, sr);
         rd_data_i = 8'(rnd());
         issue(CFBM_OP_FLAG_TO_BIT, 1);
         a = {8'h00, rd_data_i};
         a[k] = sr[CFBM_FLAG_T];
         chk({rd_we_o, rd_wdata_o, status_register_o}, {1'b1, a[7:0], sr});
      end
      rd_data_i = 8'(rnd());
      issue(CFBM_OP_SWAP, 1);
      chk({rd_we_o, rd_wdata_o}, {1'b1, rd_data_i[3:0], rd_data_i[7:4]});
      issue(CFBM_OP_WDOG, 1);
      chk({wdog_restart_o, status_register_o}, {1'b1, sr});
      idle();
      chk(wdog_restart_o, 1'b0);
      $display("flag and bit tests done");
      for (int k = 0; k < 8; k++)
      begin
         {ptr_x_i, ptr_y_i} = rnd();
         ptr_z_i = 16'(rnd());
         disp_i = 6'(rnd());
         rs_data_i = 8'(rnd());
         amode_i = cfbm_amode_t'(k / 2);
         ptr_sel_i = (k / 2 == 3) ? 2'(1 + k % 2) : 2'(k % 3);
         p = ptr_sel_i == 2'h0 ? ptr_x_i : ptr_sel_i == 2'h1 ? ptr_y_i : ptr_z_i;
         a = amode_i == CFBM_AM_PREDEC ? p - 16'h0001 : p;
         a = amode_i == CFBM_AM_DISP ? p + 16'(disp_i) : a;
         pw = amode_i == CFBM_AM_POSTINC ? {1'b1, p + 16'h0001} : 17'h00000;
         pw = amode_i == CFBM_AM_PREDEC ? {1'b1, a} : pw;
         mop(k[0] ? CFBM_OP_STORE : CFBM_OP_LOAD, a, pw);
      end
      imm_addr_i = 16'(rnd());
      rs_data_i = 8'(rnd());
      mop(CFBM_OP_STORE_DIR, imm_addr_i, 17'h00000);
      mop(CFBM_OP_LOAD_DIR, imm_addr_i, 17'h00000);
      for (int k = 0; k < 4; k++)
      begin
         rs_data_i = 8'(rnd());
         a = k < 2 ? sp : sp + 16'h0001;
         sp = k < 2 ? sp - 16'h0001 : a;
         mop(k < 2 ? CFBM_OP_PUSH : CFBM_OP_POP, a, 17'h00000);
         chk(sp_o, sp);
      end
      $display("memory and stack tests done");
      ptr_z_i = 16'(rnd());
      amode_i = CFBM_AM_POSTINC;
      issue(CFBM_OP_PM_READ, 3);
      chk({pm_re_o, busy_o, pm_addr_o}, {2'b11, ptr_z_i});
      issue(CFBM_OP_WDOG, 3);
      idle();
      chk({rd_we_o, rd_wdata_o, ptr_we_o}, {1'b1, ptr_z_i[7:0] ^ 8'h3c, 1'b1});
      chk({ptr_wdata_o, wdog_restart_o}, {ptr_z_i + 16'h0001, 1'b0});
      issue(CFBM_OP_BRK, 1);
      idle();
      chk({dbg_halt_o, status_register_o}, {1'b1, sr});
      rst_i = 1'b1;
      idle();
      rst_i = 1'b0;
      chk({dbg_halt_o, sp_o, busy_o}, {1'b0, CFBM_SP_RST, 1'b0});
      $display("control tests done");
      finish_test();
   end
endmodule // tb
